// [ssr_sram_core.sv]
// pipelined sync sram: strobed writes, burst addressing and sleep mode
//
// How it works
// - processor strobe with chip selects loads address into register and burst logic
// - processor strobe cycle ignores write inputs; first cycle after it ignores advance
// - processor-strobe write completes at second edge; global write writes all lanes
// - byte writes touch only lanes whose select is low; others keep contents
// - data drivers are off whenever a write cycle is detected
// - controller strobe with processor strobe high and selects starts an access, a write if write inputs are asserted
// - controller-strobe write completes in one cycle; advance ignored then
// - two-bit burst counter loaded from lowest address bits
// - mode low gives linear order, high gives interleaved order
// - interleaved xors count with start; linear adds modulo four
// - advance low at an edge steps the burst counter
// - sleep request is sampled at enabled clock edges; entry and exit each take two cycles
// - contents kept while asleep; pending accesses are dropped
// - processor-strobe access always starts as a read
// - write when global write low, or byte enable low with a lane selected
`timescale 1ns/1ns
`default_nettype none
`include "ssr_cfg.svh"
module ssr_sram_core
  import ssr_pkg::*;
#(
  parameter int ADDR_W = `SSR_ADDR_W,
  parameter int LANES  = `SSR_LANES,
  parameter int LANE_W = `SSR_LANE_W
) (
  input  wire logic                    clock_in,
  input  wire logic                    nrst_in,
  input  wire logic                    ce_in,
  input  wire logic [ADDR_W-1:0]       addr_in,
  input  wire logic                    chip_sel_n_in,
  input  wire logic                    chip_sel_hi_in,
  input  wire logic                    chip_sel_lo_n_in,
  input  wire logic                    proc_addr_strobe_n_in,
  input  wire logic                    ctrl_addr_strobe_n_in,
  input  wire logic                    burst_advance_n_in,
  input  wire logic                    global_write_n_in,
  input  wire logic                    byte_write_enable_n_in,
  input  wire logic [LANES-1:0]        byte_lane_select_n_in,
  input  wire logic                    output_enable_n_in,
  input  wire logic                    mode_in,
  input  wire logic                    sleep_request_in,
  input  wire logic [LANES*LANE_W-1:0] dq_in,
  output logic      [LANES*LANE_W-1:0] dq_out,
  output logic      [LANES*LANE_W-1:0] dq_oe_out,
  output logic                         asleep_out
);
  localparam int DEPTH = 1 << ADDR_W;

  // ==========================================================
  // storage and state
  logic [ADDR_W-1:0]       addr_q;
  logic                    active_q;
  logic                    first_q;
  logic                    rd_valid_q;
  logic                    mode_q;
  logic                    strap_q;
  logic [LANES*LANE_W-1:0] rdata_q;
  ssr_sleep_t              sleep_q;
  ssr_sleep_t              sleep_d;
  logic [1:0]              sleep_cnt_q;
  logic [1:0]              sleep_cnt_d;
  logic [`SSR_BURST_W-1:0] burst_lo_w;

  // ==========================================================
  // decode of strobes and write controls
  wire awake_w    = (sleep_q == SSR_AWAKE);
  wire selected_w = ~chip_sel_n_in & chip_sel_hi_in & ~chip_sel_lo_n_in;
  // processor strobe with any chip select off starts nothing and ends the access
  wire proc_go_w  = awake_w & ~proc_addr_strobe_n_in & selected_w;
  wire ctrl_go_w  = awake_w & proc_addr_strobe_n_in & ~ctrl_addr_strobe_n_in
                    & selected_w;
  wire start_w    = proc_go_w | ctrl_go_w;
  wire write_w    = ~global_write_n_in
                    | (~byte_write_enable_n_in & ~&byte_lane_select_n_in);
  // a new processor strobe forces a read regardless of write inputs
  wire wr_now_w   = awake_w & write_w & ~proc_go_w
                    & (ctrl_go_w | (active_q & ctrl_addr_strobe_n_in
                    & proc_addr_strobe_n_in));
  wire cont_w     = active_q & ~start_w & awake_w;
  wire adv_w      = cont_w & ~burst_advance_n_in & ~first_q;
  wire [ADDR_W-1:0] cur_addr_w = start_w ? addr_in
                                 : {addr_q[ADDR_W-1:`SSR_BURST_W], burst_lo_w};

  // ==========================================================
  // burst counter
  ssr_burst_counter u_burst (
    .clock_in   (clock_in),
    .ce_in      (ce_in),
    .load_in    (start_w),
    .advance_in (adv_w),
    .linear_in  (mode_q == `SSR_MODE_LINEAR),
    .start_in   (addr_in[`SSR_BURST_W-1:0]),
    .addr_out   (burst_lo_w)
  );

  // strap sampled once after reset release; not reloaded mid-operation
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      strap_q <= 1'b0;
    end else if (ce_in && !strap_q) begin
      strap_q <= 1'b1;
      mode_q  <= mode_in;
    end
  end

  // access tracking; sleep drops any pending access
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      active_q   <= 1'b0;
      first_q    <= 1'b0;
      rd_valid_q <= 1'b0;
      addr_q     <= '0;
    end else if (ce_in) begin
      if (start_w) begin
        addr_q <= addr_in;
      end
      active_q   <= awake_w & (start_w | active_q) & ~(~selected_w
                    & ~proc_addr_strobe_n_in);
      first_q    <= proc_go_w;
      rd_valid_q <= awake_w & (start_w | active_q) & ~wr_now_w;
    end
  end

  // ==========================================================
  // array write per lane, and registered read data
  for (genvar g = 0; g < LANES; g++) begin : g_lane
    // each lane keeps its own array, so one process alone writes it
    logic [LANE_W-1:0] lane_mem [DEPTH];
    wire lane_we_w = wr_now_w & (~global_write_n_in
                     | ~byte_lane_select_n_in[g]);
    always_ff @(posedge clock_in) begin
      if (ce_in && lane_we_w) begin
        lane_mem[cur_addr_w] <= dq_in[g*LANE_W +: LANE_W];
      end
      if (ce_in) begin
        rdata_q[g*LANE_W +: LANE_W] <= lane_mem[cur_addr_w];
      end
    end
  end

  // drivers off on writes, sleep or output enable high
  wire drive_w = rd_valid_q & ~write_w & ~output_enable_n_in & awake_w;
  assign dq_out    = rdata_q;
  assign dq_oe_out = {(LANES*LANE_W){drive_w}};

  // ==========================================================
  // sleep sequencer, two cycles each way
  always_comb begin
    sleep_d     = sleep_q;
    sleep_cnt_d = sleep_cnt_q;
    case (sleep_q)
      SSR_AWAKE: begin
        if (sleep_request_in) begin
          sleep_d     = SSR_ENTERING;
          sleep_cnt_d = 2'(`SSR_SLEEP_CYC - 1);
        end
      end
      SSR_ENTERING: begin
        if (sleep_cnt_q == 2'h1) begin
          sleep_d = SSR_ASLEEP;
        end
        sleep_cnt_d = sleep_cnt_q - 2'h1;
      end
      SSR_ASLEEP: begin
        if (!sleep_request_in) begin
          sleep_d     = SSR_WAKING;
          sleep_cnt_d = 2'(`SSR_RECOVERY_CYC - 1);
        end
      end
      SSR_WAKING: begin
        if (sleep_cnt_q == 2'h1) begin
          sleep_d = SSR_AWAKE;
        end
        sleep_cnt_d = sleep_cnt_q - 2'h1;
      end
      default: begin
        sleep_d = SSR_AWAKE;
      end
    endcase
  end

  // sleep register; memory array is untouched here so contents survive
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      sleep_q     <= SSR_AWAKE;
      sleep_cnt_q <= 2'h0;
    end else if (ce_in) begin
      sleep_q     <= sleep_d;
      sleep_cnt_q <= sleep_cnt_d;
    end
  end

  assign asleep_out = (sleep_q == SSR_ASLEEP);
endmodule : ssr_sram_core
`default_nettype wire

// [ssr_cfg.svh]
// timing and strap constants for the sync sram write, burst and sleep logic
`ifndef SSR_CFG_SVH
`define SSR_CFG_SVH
`define SSR_ADDR_W        10
`define SSR_LANES         4
`define SSR_LANE_W        9
`define SSR_BURST_W       2
`define SSR_SLEEP_CYC     2
`define SSR_RECOVERY_CYC  2
`define SSR_MODE_LINEAR   1'b0
`endif

// [ssr_pkg.sv]
// types shared by the sync sram logic
package ssr_pkg;
  typedef enum logic [3:0] {
    SSR_AWAKE    = 4'h1,
    SSR_ENTERING = 4'h2,
    SSR_ASLEEP   = 4'h4,
    SSR_WAKING   = 4'h8
  } ssr_sleep_t;
endpackage : ssr_pkg

// [ssr_burst_counter.sv]
// two-bit wraparound burst counter with linear or interleaved order
`timescale 1ns/1ns
`default_nettype none
`include "ssr_cfg.svh"
module ssr_burst_counter
  import ssr_pkg::*;
(
  input  wire logic                    clock_in,
  input  wire logic                    ce_in,
  input  wire logic                    load_in,
  input  wire logic                    advance_in,
  input  wire logic                    linear_in,
  input  wire logic [`SSR_BURST_W-1:0] start_in,
  output logic      [`SSR_BURST_W-1:0] addr_out
);
  logic [`SSR_BURST_W-1:0] start_q;
  logic [`SSR_BURST_W-1:0] count_q;
  logic [`SSR_BURST_W-1:0] count_d;
  logic [`SSR_BURST_W-1:0] sum_w;
  logic [`SSR_BURST_W-1:0] step_w;
  // an advancing cycle already uses the next address of the burst, not the old one
  assign step_w   = advance_in ? count_q + 2'h1 : count_q;
  // load restarts at zero; there is no reset, a load always comes first
  assign count_d  = load_in ? '0 : step_w;
  assign sum_w    = start_q + step_w;
  assign addr_out = linear_in ? sum_w : (start_q ^ step_w);
  // state only moves with the clock enable high
  always_ff @(posedge clock_in) begin
    if (ce_in) begin
      count_q <= count_d;
      if (load_in) begin
        start_q <= start_in;
      end
    end
  end
endmodule : ssr_burst_counter
`default_nettype wire

// [ssr_asserts.sv]
// port checker for the sync sram core
`timescale 1ns/1ns
`default_nettype none
module ssr_asserts #(parameter int W = 36) (
  input wire logic         clock_in,
  input wire logic         nrst_in,
  input wire logic         ce_in,
  input wire logic         chip_sel_hi_in,
  input wire logic         proc_addr_strobe_n_in,
  input wire logic         ctrl_addr_strobe_n_in,
  input wire logic         global_write_n_in,
  input wire logic         output_enable_n_in,
  input wire logic         sleep_request_in,
  input wire logic [W-1:0] dq_oe_out,
  input wire logic         asleep_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!nrst_in);
  // ======================================
  // write cycles, output enable high and sleep keep the shared lines released
  sequence s_proc_wr;
    chip_sel_hi_in && !proc_addr_strobe_n_in && ce_in
      ##1 proc_addr_strobe_n_in && ctrl_addr_strobe_n_in && !global_write_n_in;
  endsequence
  sequence s_nap;
    (sleep_request_in && ce_in)[*4];
  endsequence
  a_proc_wr_hiz: assert property (s_proc_wr |-> dq_oe_out == '0)
    else $error("proc write drove data");
  a_ctrl_wr_hiz: assert property (chip_sel_hi_in && proc_addr_strobe_n_in &&
    !ctrl_addr_strobe_n_in && !global_write_n_in |-> dq_oe_out == '0)
    else $error("ctrl write drove data");
  a_oe_off_hiz: assert property (output_enable_n_in |-> dq_oe_out == '0)
    else $error("driven with enable off");
  a_asleep_hiz: assert property (asleep_out |-> dq_oe_out == '0)
    else $error("driven while asleep");
  // ======================================
  // entry and exit each take two cycles
  a_sleep_entry: assert property (s_nap |=> asleep_out)
    else $error("sleep not entered");
  a_sleep_late: assert property ($rose(sleep_request_in) && !asleep_out |=> !asleep_out)
    else $error("sleep entered early");
  a_wake_exit: assert property ((!sleep_request_in && ce_in)[*3] |=> !asleep_out)
    else $error("sleep not left");
  a_asleep_cause: assert property ($rose(asleep_out) |-> $past(sleep_request_in))
    else $error("asleep without request");
endmodule : ssr_asserts
`default_nettype wire

// [ssr_host.sv]
// processor or cache controller model driving the sram pins
`timescale 1ns/1ns
`default_nettype none
module ssr_host (
  input wire logic clock_in,
  output logic [9:0] addr_in,
  output logic chip_sel_n_in,
  output logic chip_sel_hi_in,
  output logic chip_sel_lo_n_in,
  output logic proc_addr_strobe_n_in,
  output logic ctrl_addr_strobe_n_in,
  output logic burst_advance_n_in,
  output logic global_write_n_in,
  output logic byte_write_enable_n_in,
  output logic [3:0] byte_lane_select_n_in,
  output logic output_enable_n_in,
  output logic sleep_request_in,
  output logic [35:0] dq_in
);
  // ======================================
  // one bus cycle, launched after the falling edge
  task automatic cyc(input logic s, input logic [9:0] a, input logic p, c, v, g, b,
                     input logic [3:0] l, input logic [35:0] d);
    @(negedge clock_in);
    {chip_sel_n_in, chip_sel_hi_in, chip_sel_lo_n_in} = {!s, s, !s};
    addr_in = a;
    {proc_addr_strobe_n_in, ctrl_addr_strobe_n_in, burst_advance_n_in} = {p, c, v};
    {global_write_n_in, byte_write_enable_n_in, byte_lane_select_n_in} = {g, b, l};
    output_enable_n_in = !(g && (b || &l));
    dq_in = (g && (b || &l)) ? ~dq_in : d; // released lines toggle, never hold
  endtask
  // deselect first, then sleep; strobes stay idle well past recovery
  task automatic nap(input logic s);
    cyc(0, addr_in, 0, 1, 1, 1, 1, 4'hF, dq_in);
    repeat (6) begin
      cyc(0, addr_in, 1, 1, 1, 1, 1, 4'hF, dq_in);
      sleep_request_in = s;
    end
  endtask
  initial begin
    sleep_request_in = 1'b0;
    cyc(0, 10'h000, 1, 1, 1, 1, 1, 4'hF, 36'h0);
  end
endmodule : ssr_host
`default_nettype wire

// [sync_sram_write_burst_sleep_bench.sv]
// self-checking bench for the sync sram core
`timescale 1ns/1ns
`default_nettype none
module sync_sram_write_burst_sleep_bench;
  logic clock_in = 1'b0, nrst_in = 1'b0, mode_in = 1'b0;
  wire logic [9:0] addr_in;
  wire logic chip_sel_n_in, chip_sel_hi_in, chip_sel_lo_n_in, proc_addr_strobe_n_in;
  wire logic ctrl_addr_strobe_n_in, burst_advance_n_in, global_write_n_in;
  wire logic byte_write_enable_n_in, output_enable_n_in, sleep_request_in, asleep_out;
  wire logic [3:0] byte_lane_select_n_in;
  wire logic [35:0] dq_in, dq_out, dq_oe_out;
  logic [35:0] mem [bit [9:0]];
  logic [9:0] a;
  int error_cnt = 0, checked = 0;
  initial forever #5 clock_in = ~clock_in;
  ssr_host i_host (.clock_in, .addr_in, .chip_sel_n_in, .chip_sel_hi_in, .chip_sel_lo_n_in,
    .proc_addr_strobe_n_in, .ctrl_addr_strobe_n_in, .burst_advance_n_in, .global_write_n_in,
    .byte_write_enable_n_in, .byte_lane_select_n_in, .output_enable_n_in,
    .sleep_request_in, .dq_in);
  ssr_sram_core i_dut (.clock_in, .nrst_in, .ce_in(1'b1), .addr_in, .chip_sel_n_in,
    .chip_sel_hi_in, .chip_sel_lo_n_in, .proc_addr_strobe_n_in, .ctrl_addr_strobe_n_in,
    .burst_advance_n_in, .global_write_n_in, .byte_write_enable_n_in,
    .byte_lane_select_n_in, .output_enable_n_in, .mode_in, .sleep_request_in, .dq_in,
    .dq_out, .dq_oe_out, .asleep_out);
  // ======================================
  // expectations: lane merge and burst order
  function automatic logic [35:0] merge(input logic [35:0] o, n, input logic g, b,
                                        input logic [3:0] l);
    for (int k = 0; k < 4; k++)
      if (!g || (!b && !l[k])) o[k*9 +: 9] = n[k*9 +: 9];
    return o;
  endfunction : merge
  function automatic logic [1:0] nxt(input logic [1:0] s, input int k);
    return mode_in ? s ^ k[1:0] : s + k[1:0];
  endfunction : nxt
  task automatic cmp(input string what, input logic [35:0] exp, got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  task automatic rd(input logic [9:0] ra);
    i_host.cyc(1, ra, 0, 1, 1, 1, 1, 4'hF, '0);
    i_host.cyc(0, ra, 1, 1, 1, 1, 1, 4'hF, '0);
    @(negedge clock_in);
    cmp("read data", mem[ra], dq_out);
    cmp("read drive", {36{1'b1}}, dq_oe_out);
  endtask : rd
  // proc start carries random write and advance values the core must ignore
  task automatic wr(input bit ctl, input logic [9:0] wa, input logic [35:0] d,
                    input logic g, b, input logic [3:0] l);
    if (ctl) i_host.cyc(1, wa, 1, 0, 1, g, b, l, d);
    else begin
      i_host.cyc(1, wa, 0, 1, 1'($urandom), 1'($urandom), 1, 4'hF, ~d);
      i_host.cyc(0, wa, 1, 1, 1, g, b, l, d);
    end
    mem[wa] = merge(mem[wa], d, g, b, l);
  endtask : wr
  task automatic burst(input logic [9:0] ba);
    logic [35:0] d;
    i_host.cyc(1, ba, 0, 1, 1, 1, 1, 4'hF, '0);
    for (int k = 0; k < 4; k++) begin
      d = 36'({$urandom, $urandom});
      i_host.cyc(0, ba, 1, 1, k == 0, 0, 1, 4'hF, d);
      mem[{ba[9:2], nxt(ba[1:0], k)}] = d;
    end
  endtask : burst
  task automatic end_of_test;
    $display("checked %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_of_test
  initial begin
    #200000;
    error_cnt++;
    end_of_test;
  end
  // ======================================
  // both burst orders, random writes, then a sleep round trip
  initial begin
    void'($urandom(62));
    for (int m = 0; m < 2; m++) begin
      @(negedge clock_in);
      nrst_in = 1'b0;
      mode_in = m[0];
      repeat (4) @(negedge clock_in);
      nrst_in = 1'b1;
      for (int i = 0; i < 12; i++) begin
        a = 10'($urandom);
        wr(1, a, 36'({$urandom, $urandom}), 0, 1, 4'hF);
        wr(1'($urandom), a, 36'({$urandom, $urandom}), 1'($urandom), 1'($urandom),
           4'($urandom));
        rd(a);
      end
      for (int s = 0; s < 4; s++) begin
        a = {8'($urandom), 2'(s)};
        burst(a);
        for (int k = 0; k < 4; k++) rd({a[9:2], nxt(a[1:0], k)});
      end
      $display("burst order %0d done", m);
    end
    i_host.nap(1);
    cmp("asleep", 36'h1, 36'(asleep_out));
    i_host.nap(0);
    cmp("awake", 36'h0, 36'(asleep_out));
    rd(a);
    $display("sleep test done");
    end_of_test;
  end
endmodule : sync_sram_write_burst_sleep_bench
bind ssr_sram_core ssr_asserts #(.W(LANES*LANE_W)) i_chk (.clock_in, .nrst_in, .ce_in,
  .chip_sel_hi_in, .proc_addr_strobe_n_in, .ctrl_addr_strobe_n_in, .global_write_n_in,
  .output_enable_n_in, .sleep_request_in, .dq_oe_out, .asleep_out);
`default_nettype wire
